// [rtl/core_decode_regs.vh]
// Constants for the instruction decode and cycle-timing block.
// Assumes a single clock and instruction words presented in step with it.
// Summary of operation
// RULE_01 - Every instruction is one 14-bit word that holds its opcode and all of its operands.
// RULE_02 - Opcodes are sorted into byte-oriented file, bit-oriented file and literal/control classes.
// RULE_03 - Any instruction that is not a listed exception finishes in one instruction cycle.
// RULE_04 - The direct call and the call through the working register take two cycles.
// RULE_05 - Plain return, return with literal and interrupt return take two cycles each.
// RULE_06 - Jump, relative branch and branch by W take two cycles, and skips take two when taken.
// RULE_07 - Indirect file access through a pointer into program memory adds one more cycle.
// RULE_08 - One instruction cycle lasts four oscillator clocks.
// RULE_09 - A file-register target is always read, then modified, then stored, even if only written.
// RULE_10 - Destination bit 0 sends the result to W and bit 1 sends it back to the file register.
// RULE_11 - The file-address field selects a register from 0x00 to 0x7F of the current bank.
// RULE_12 - The bit-address field selects one bit of the addressed 8-bit file register.
// RULE_13 - Don't-care bits are ignored and may hold either value.
// RULE_14 - The pointer-number field chooses pointer pair 0 or 1.
// RULE_15 - The two-bit mode field selects pre-increment, pre-decrement, post-increment or post-decrement.
// RULE_16 - A word outside the defined encodings executes as a one-cycle no-operation.
`ifndef CORE_DECODE_REGS_VH
`define CORE_DECODE_REGS_VH

// ************************************************************
// Word layout
// ************************************************************
`define WORD_W          14
`define FADDR_W         7
`define FADDR_LSB       0
`define DEST_BIT        7
`define BITSEL_LSB      7
`define BITSEL_W        3
`define LIT_W           8
`define PTRN_BIT        2
`define PTRMODE_LSB     0

// ************************************************************
// Classes
// ************************************************************
`define CLASS_BYTE      2'b00
`define CLASS_BIT       2'b01
`define CLASS_LITCTL    2'b10
`define CLASS_NOP       2'b11

// ************************************************************
// Fixed encodings, pattern and care mask
// ************************************************************
`define CALL_MASK       14'h3800
`define CALL_PAT        14'h2000
`define JUMP_MASK       14'h3800
`define JUMP_PAT        14'h2800
`define RBR_MASK        14'h3e00
`define RBR_PAT         14'h3200
`define BTSC_MASK       14'h3c00
`define BTSC_PAT        14'h1800
`define BTSS_MASK       14'h3c00
`define BTSS_PAT        14'h1c00
`define DSZ_MASK        14'h3f00
`define DSZ_PAT         14'h0b00
`define ISZ_MASK        14'h3f00
`define ISZ_PAT         14'h0f00
`define CTL_REGION_MASK 14'h3f80
`define CTL_REGION_PAT  14'h0000

// ************************************************************
// Timing and reset values
// ************************************************************
`define CLKS_PER_ICYC   4
`define PHASE_READ      2'd1
`define PHASE_WRITE     2'd3
`define RST_WORD        14'h0000

`endif

// [rtl/icycle_divider.v]
// Instruction-cycle phase divider.
// Assumes clk is the oscillator clock and nrst an asynchronous active-low reset.
`include "core_decode_regs.vh"

module icycle_divider #(
  parameter CLKS = `CLKS_PER_ICYC
) (
  input  wire       clk,
  input  wire       nrst,
  output reg  [1:0] phase_q,
  output reg        cyc_start_q
);

  // ************************************************************
  // Phase counter
  // ************************************************************
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      phase_q     <= 2'd0;
      cyc_start_q <= 1'b0;
    end
    else
    begin
      // Four clocks per instruction cycle [RULE_08]
      if (phase_q == CLKS - 1)
        phase_q <= 2'd0;
      else
        phase_q <= phase_q + 2'd1;
      cyc_start_q <= (phase_q == CLKS - 1);
    end
  end

endmodule

// [rtl/core_decode_timing.v]
// Instruction decoder and cycle sequencer.
// Assumes program memory presents instr_word valid on the clock after fetch_q,
// that skip_cond is steady by the write phase, and that ptr_in_prog is steady at the cycle start.
`include "core_decode_regs.vh"

module core_decode_timing #(
  // Encodings of these control words are not fixed here; values are arbitrary
  parameter [13:0] WCALL_PAT   = 14'h000a,
  parameter [13:0] RET_PAT     = 14'h0008,
  parameter [13:0] RETLIT_MASK = 14'h3f00,
  parameter [13:0] RETLIT_PAT  = 14'h3400,
  parameter [13:0] IRET_PAT    = 14'h0009,
  parameter [13:0] WBR_PAT     = 14'h000b,
  parameter [13:0] IND_MASK    = 14'h3ff0,
  parameter [13:0] IND_PAT     = 14'h0010,
  parameter [6:0]  IND_PORT0   = 7'h00,
  parameter [6:0]  IND_PORT1   = 7'h01
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire [13:0] instr_word,
  input  wire        skip_cond,
  input  wire [1:0]  ptr_in_prog,
  output reg         fetch_q,
  output reg         instr_start_q,
  output reg         extra_cycle_q,
  output reg  [1:0]  op_class_q,
  output reg  [6:0]  file_addr_q,
  output reg  [2:0]  bit_sel_q,
  output reg  [7:0]  literal_q,
  output reg         dest_file_q,
  output reg         ptr_sel_q,
  output reg  [1:0]  pointer_update_mode_q,
  output reg         ptr_update_q,
  output reg         file_rd_q,
  output reg         file_wr_q,
  output reg         wreg_wr_q,
  output reg  [1:0]  phase_q
);

  wire [1:0] phase;
  wire       cyc_start;

  // ************************************************************
  // Instruction-cycle divider
  // ************************************************************
  // cyc_start marks phase 0 of every instruction cycle [RULE_08]
  // Kept apart, though the two-bit phase_q and the fixed read and write phases tie CLKS to 4
  icycle_divider u_div (
    .clk         (clk),
    .nrst        (nrst),
    .phase_q     (phase),
    .cyc_start_q (cyc_start)
  );

  // ************************************************************
  // Combinational decode of the incoming word
  // ************************************************************
  // Masks leave don't-care bits out of the masked compares; W call, return, interrupt return and W branch match whole words [RULE_13]
  wire is_call_dir = ((instr_word & `CALL_MASK) == `CALL_PAT);
  wire is_call_w   = (instr_word == WCALL_PAT);
  wire is_call     = is_call_dir || is_call_w;
  wire is_ret_sub  = (instr_word == RET_PAT);
  wire is_ret_int  = (instr_word == IRET_PAT);
  wire is_ret_lit  = ((instr_word & RETLIT_MASK) == RETLIT_PAT);
  wire is_ret      = is_ret_sub || is_ret_int || is_ret_lit;
  wire is_jump     = ((instr_word & `JUMP_MASK) == `JUMP_PAT);
  wire is_relbr    = ((instr_word & `RBR_MASK) == `RBR_PAT);
  wire is_wbr      = (instr_word == WBR_PAT);
  wire is_branch   = is_jump || is_relbr || is_wbr;
  // Skips: the two bit tests and the two counting file operations
  wire is_skip   = ((instr_word & `BTSC_MASK) == `BTSC_PAT)
                 || ((instr_word & `BTSS_MASK) == `BTSS_PAT)
                 || ((instr_word & `DSZ_MASK) == `DSZ_PAT)
                 || ((instr_word & `ISZ_MASK) == `ISZ_PAT);
  wire skip_on_set = ((instr_word & `BTSS_MASK) == `BTSS_PAT);
  wire is_ind    = ((instr_word & IND_MASK) == IND_PAT);
  wire in_ctl    = ((instr_word & `CTL_REGION_MASK) == `CTL_REGION_PAT);
  wire [1:0] top = instr_word[13:12];
  wire [3:0] nib = instr_word[11:8];
  wire byte11    = (top == 2'b11) && ((nib == 4'h5) || (nib == 4'h6) || (nib == 4'h7)
                 || (nib == 4'hb) || (nib == 4'hd));
  wire is_byte   = ((top == 2'b00) && !in_ctl) || byte11;
  wire is_bit    = (top == 2'b01);
  wire ctl_known = is_call || is_ret || is_branch || is_ind;
  wire [6:0] faddr = instr_word[`FADDR_LSB +: `FADDR_W];
  // A file operand that names an access port goes through that port's pointer
  wire ind_ref   = (is_byte || is_bit) && ((faddr == IND_PORT0) || (faddr == IND_PORT1));
  wire ind_ptr   = (faddr == IND_PORT1);

  // ************************************************************
  // Class select
  // ************************************************************
  reg [1:0] cls;
  always @*
  begin
    cls = `CLASS_LITCTL;
    // Three classes, with unmatched control words falling to a no-op [RULE_02] [RULE_16]
    if (is_byte)
      cls = `CLASS_BYTE;
    else if (is_bit)
      cls = `CLASS_BIT;
    else if (in_ctl && !ctl_known)
      cls = `CLASS_NOP;
  end

  // Two-cycle classes and the program-memory pointer penalty
  wire two_cyc   = is_call || is_ret || is_branch;                // [RULE_04] [RULE_05] [RULE_06]
  wire ind_slow  = (ind_ref && ptr_in_prog[ind_ptr])
                 || (is_ind && ptr_in_prog[instr_word[`PTRN_BIT]]); // [RULE_07]
  // Never more than two owed cycles, so two bits hold the sum
  wire [1:0] extra = {1'b0, two_cyc} + {1'b0, ind_slow};

  // ************************************************************
  // Cycle sequencer
  // ************************************************************
  // left_q holds the cycles still owed after the current one; first_q marks
  // the first cycle, the only one in which the file is read or written.
  // A taken skip adds its cycle in the write phase, well after decode.
  reg [1:0] left_q;
  reg       first_q;
  reg       skip_op_q;
  reg       skip_set_q;
  reg       uses_file_q;

  // Set-skips and counting skips are taken on skip_cond high, clear-skips on
  // it low; skip_cond is live, so this only counts in the first write phase
  wire skip_taken = skip_op_q && (skip_cond ^ ((op_class_q == `CLASS_BIT) && !skip_set_q));

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      left_q                <= 2'd0;
      first_q               <= 1'b0;
      skip_op_q             <= 1'b0;
      skip_set_q            <= 1'b0;
      uses_file_q           <= 1'b0;
      fetch_q               <= 1'b0;
      instr_start_q         <= 1'b0;
      extra_cycle_q         <= 1'b0;
      op_class_q            <= `CLASS_NOP;
      file_addr_q           <= 7'h00;
      bit_sel_q             <= 3'd0;
      literal_q             <= 8'h00;
      dest_file_q           <= 1'b0;
      ptr_sel_q             <= 1'b0;
      pointer_update_mode_q <= 2'd0;
      ptr_update_q          <= 1'b0;
      file_rd_q             <= 1'b0;
      file_wr_q             <= 1'b0;
      wreg_wr_q             <= 1'b0;
      phase_q               <= 2'd0;
    end
    else
    begin
      phase_q       <= phase;
      instr_start_q <= 1'b0;
      fetch_q       <= 1'b0;
      ptr_update_q  <= 1'b0;
      file_rd_q     <= 1'b0;
      file_wr_q     <= 1'b0;
      wreg_wr_q     <= 1'b0;
      if (cyc_start)
      begin
        if (left_q == 2'd0)
        begin
          // Whole word taken at once: opcode and operands together [RULE_01]
          instr_start_q <= 1'b1;
          extra_cycle_q <= 1'b0;
          first_q       <= 1'b1;
          left_q        <= extra;                                   // [RULE_03]
          op_class_q    <= cls;
          file_addr_q   <= faddr;                                   // [RULE_11]
          bit_sel_q     <= instr_word[`BITSEL_LSB +: `BITSEL_W];    // [RULE_12]
          literal_q     <= instr_word[`LIT_W-1:0];
          dest_file_q   <= is_bit || instr_word[`DEST_BIT];         // [RULE_10]
          ptr_sel_q     <= is_ind ? instr_word[`PTRN_BIT] : ind_ptr; // [RULE_14]
          pointer_update_mode_q <= instr_word[`PTRMODE_LSB +: 2];   // [RULE_15]
          ptr_update_q  <= is_ind;
          skip_op_q     <= is_skip;
          skip_set_q    <= skip_on_set;
          uses_file_q   <= is_byte || is_bit;
        end
        else
        begin
          left_q        <= left_q - 2'd1;
          extra_cycle_q <= 1'b1;
          first_q       <= 1'b0;
        end
      end
      else if (first_q)
      begin
        // Read always precedes the store, even for write-only targets [RULE_09]
        if (phase == `PHASE_READ)
          file_rd_q <= uses_file_q;
        if (phase == `PHASE_WRITE)
        begin
          file_wr_q <= uses_file_q && dest_file_q && !skip_set_q_bitop(skip_op_q);
          wreg_wr_q <= uses_file_q && !dest_file_q;                 // [RULE_10]
          // A taken skip costs one more cycle [RULE_06]
          if (skip_taken)
            left_q <= left_q + 2'd1;
        end
      end
      // Fetch the following word in the last cycle of this instruction
      if (phase == `PHASE_WRITE && left_q == 2'd0 && !(first_q && skip_taken))
        fetch_q <= 1'b1;
    end
  end

  // ************************************************************
  // Helper
  // ************************************************************
  // Bit-test skips only read their file register; counting skips write it back when dest_file_q is set
  function skip_set_q_bitop;
    input sk;
    begin
      skip_set_q_bitop = sk && (op_class_q == `CLASS_BIT);
    end
  endfunction

endmodule

// [sim/prog_mem_model.sv]
// Program memory model: one instruction word per instruction.
// Assumes the bench fills mem before reset is released.
module prog_mem_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        instr_start_q,
  output      logic [13:0] instr_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] mem [256];
  logic [7:0]  idx_q;

  // Next word is offered once the current one is taken, so it is never late
  always @(posedge clk or negedge nrst)
    if (!nrst)
      idx_q <= 8'h00;
    else if (instr_start_q)
      idx_q <= idx_q + 8'h01;

  assign instr_word = mem[idx_q];
endmodule

// [sim/core_decode_timing_chk.sv]
// Checker for the decode and timing block, watching its ports only.
// Assumes one clock and an asynchronous active-low reset.
`include "core_decode_regs.vh"
module core_decode_timing_chk (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       instr_start_q,
  input wire logic       extra_cycle_q,
  input wire logic [1:0] op_class_q,
  input wire logic       dest_file_q,
  input wire logic       file_rd_q,
  input wire logic       file_wr_q,
  input wire logic       wreg_wr_q,
  input wire logic [1:0] phase_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_quarters;
    phase_q == 2'd0 ##1 phase_q == 2'd1 ##1 phase_q == 2'd2 ##1 phase_q == 2'd3;
  endsequence
  sequence s_quiet;
    (!file_rd_q && !file_wr_q && !wreg_wr_q) [*3];
  endsequence
  property p_phase; phase_q == 2'd3 |=> s_quarters; endproperty
  a_phase: assert property (p_phase) else $error("phase order wrong");
  property p_gap; instr_start_q |=> !instr_start_q [*3]; endproperty
  a_gap: assert property (p_gap) else $error("start too soon");
  property p_next; instr_start_q |-> ##[4:12] instr_start_q; endproperty
  a_next: assert property (p_next) else $error("start too late");
  property p_rd;
    instr_start_q && !op_class_q[1] |-> ##1 file_rd_q;
  endproperty
  a_rd: assert property (p_rd) else $error("file read missing");
  property p_to_w;
    instr_start_q && op_class_q == `CLASS_BYTE && !dest_file_q |-> ##3 wreg_wr_q && !file_wr_q;
  endproperty
  a_to_w: assert property (p_to_w) else $error("result not to W");
  property p_to_f;
    instr_start_q && op_class_q == `CLASS_BYTE && dest_file_q |-> ##3 file_wr_q && !wreg_wr_q;
  endproperty
  a_to_f: assert property (p_to_f) else $error("result not to file");
  property p_long; instr_start_q ##4 !instr_start_q |-> extra_cycle_q; endproperty
  a_long: assert property (p_long) else $error("extra cycle flag low");
  property p_nop;
    instr_start_q && op_class_q == `CLASS_NOP |=> s_quiet ##1 instr_start_q;
  endproperty
  a_nop: assert property (p_nop) else $error("no-op misbehaved");
endmodule

bind core_decode_timing core_decode_timing_chk u_chk (
  .clk           (clk),
  .nrst          (nrst),
  .instr_start_q (instr_start_q),
  .extra_cycle_q (extra_cycle_q),
  .op_class_q    (op_class_q),
  .dest_file_q   (dest_file_q),
  .file_rd_q     (file_rd_q),
  .file_wr_q     (file_wr_q),
  .wreg_wr_q     (wreg_wr_q),
  .phase_q       (phase_q)
);

// [sim/core_decode_timing_bench.sv]
// Self-checking bench for the decode and timing block.
// Assumes the memory model feeds words and the checker is bound to the block.
`include "core_decode_regs.vh"
module core_decode_timing_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [13:0] w; logic [1:0] c; int k; logic r, f, x, s; logic [1:0] p;} rec_t;
  logic        clk, nrst, skip_cond, fetch_q, instr_start_q, extra_cycle_q, dest_file_q;
  logic        ptr_sel_q, ptr_update_q, file_rd_q, file_wr_q, wreg_wr_q, have;
  logic [1:0]  ptr_in_prog, op_class_q, pointer_update_mode_q, phase_q;
  logic [13:0] instr_word;
  logic [6:0]  file_addr_q;
  logic [2:0]  bit_sel_q;
  logic [7:0]  literal_q;
  logic [31:0] r;
  logic [13:0] two [8] = '{14'h2123, 14'h2a45, 14'h3267, 14'h000a,
                           14'h0008, 14'h0009, 14'h000b, 14'h3489};
  rec_t        prog [256];
  rec_t        expq [$];
  rec_t        cur;
  int          error_cnt, n_tests, n, cyc, gap, nrd, nwr, nww, nft, i;

  core_decode_timing u_dut (
    .clk                   (clk),
    .nrst                  (nrst),
    .instr_word            (instr_word),
    .skip_cond             (skip_cond),
    .ptr_in_prog           (ptr_in_prog),
    .fetch_q               (fetch_q),
    .instr_start_q         (instr_start_q),
    .extra_cycle_q         (extra_cycle_q),
    .op_class_q            (op_class_q),
    .file_addr_q           (file_addr_q),
    .bit_sel_q             (bit_sel_q),
    .literal_q             (literal_q),
    .dest_file_q           (dest_file_q),
    .ptr_sel_q             (ptr_sel_q),
    .pointer_update_mode_q (pointer_update_mode_q),
    .ptr_update_q          (ptr_update_q),
    .file_rd_q             (file_rd_q),
    .file_wr_q             (file_wr_q),
    .wreg_wr_q             (wreg_wr_q),
    .phase_q               (phase_q)
  );
  prog_mem_model u_mem (
    .clk           (clk),
    .nrst          (nrst),
    .instr_start_q (instr_start_q),
    .instr_word    (instr_word)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Loads a word into memory and notes what it must do
  task automatic add(input logic [13:0] w, input logic [1:0] c, input int k,
                     input logic rd, wf, ww, s, input logic [1:0] p);
    prog[n] = '{w, c, k, rd, wf, ww, s, p};
    u_mem.mem[n] = w;
    expq.push_back(prog[n]);
    n++;
  endtask

  // ALU side: pointer state at decode, skip outcome for the running word
  always @(negedge clk)
  begin
    ptr_in_prog <= prog[u_mem.idx_q].p;
    skip_cond <= prog[u_mem.idx_q - 8'd1].s;
  end

  always @(negedge clk)
    if (nrst)
    begin
      gap++;
      nrd += file_rd_q;
      nwr += file_wr_q;
      nww += wreg_wr_q;
      nft += fetch_q;
      if (instr_start_q)
      begin
        if (have)
        begin
          check("cycles", gap, cur.k);
          check("fetches", nft, 1);
          check("reads", nrd, cur.r);
          check("file writes", nwr, cur.f);
          check("w writes", nww, cur.x);
        end
        have = expq.size() > 0;
        if (have)
        begin
          cur = expq.pop_front();
          check("class", op_class_q, cur.c);
          if (!cur.c[1]) check("address", file_addr_q, cur.w[6:0]);
          if (cur.c == `CLASS_BIT) check("bit", bit_sel_q, cur.w[9:7]);
          if (cur.c == `CLASS_BYTE) check("dest", dest_file_q, cur.w[7]);
          if (cur.c == `CLASS_LITCTL) check("literal", literal_q, cur.w[7:0]);
          if (cur.w[13:4] == 10'h001)
            check("pointer", {ptr_sel_q, pointer_update_mode_q}, cur.w[2:0]);
          check("ptr update", ptr_update_q, cur.w[13:4] == 10'h001);
        end
        gap = 0;
        nft = 0;
        nrd = 0;
        nwr = 0;
        nww = 0;
      end
    end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      error_cnt++;
      conclude;
    end
  end

  initial
  begin
    nrst = 1'b0;
    skip_cond = 1'b0;
    ptr_in_prog = 2'b00;
    for (i = 0; i < 256; i++)
    begin
      prog[i] = '{14'h0000, 2'b11, 4, 0, 0, 0, 0, 2'b00};
      u_mem.mem[i] = 14'h0000;
    end
    void'($urandom(98807));
    for (i = 0; i < 4; i++)
    begin
      r = $urandom;
      add({6'h07, r[7:0]}, `CLASS_BYTE, 4, 1, r[7], !r[7], 0, 2'b00);
      add({4'h5, r[17:8]}, `CLASS_BIT, 4, 1, 1, 0, 0, 2'b00);
    end
    for (i = 0; i < 2; i++)
    begin
      add(14'h1805, `CLASS_BIT, i ? 4 : 8, 1, 0, 0, i[0], 2'b00);
      add(14'h1c85, `CLASS_BIT, i ? 8 : 4, 1, 0, 0, i[0], 2'b00);
      add(14'h0ba0, `CLASS_BYTE, i ? 8 : 4, 1, 1, 0, i[0], 2'b00);
      add(14'h0f21, `CLASS_BYTE, i ? 8 : 4, 1, 0, 1, i[0], 2'b00);
    end
    foreach (two[j]) add(two[j], `CLASS_LITCTL, 8, 0, 0, 0, 0, 2'b00);
    for (i = 0; i < 8; i++)
      add({11'h002, i[2:0]}, `CLASS_LITCTL, i[0] ? 8 : 4, 0, 0, 0, 0,
          i[0] ? {i[2], !i[2]} : {!i[2], i[2]});
    add(14'h0780, `CLASS_BYTE, 8, 1, 1, 0, 0, 2'b01);
    add(14'h0781, `CLASS_BYTE, 4, 1, 1, 0, 0, 2'b01);
    add(14'h30a5, `CLASS_LITCTL, 4, 0, 0, 0, 0, 2'b00);
    add(14'h0005, `CLASS_NOP, 4, 0, 0, 0, 0, 2'b00);
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    wait (expq.size() == 0);
    repeat (16) @(negedge clk);
    conclude;
  end
endmodule
